// file: adsr_map.svh
// register offsets, fields and timing counts for the converter start/reference control
`ifndef ADSR_MAP_SVH
`define ADSR_MAP_SVH
`define ADSR_ADDR_W 8
`define ADSR_OFS_RESULT 8'hD9
`define ADSR_OFS_REFPROG 8'hDA
`define ADSR_OFS_CTRL 8'hD8
`define ADSR_CTRL_CONT_BIT 3
`define ADSR_CTRL_ACTIVE_BIT 4
`define ADSR_CTRL_EXT_BIT 5
`define ADSR_RESULT_RST 8'h00
`define ADSR_REFPROG_RST 8'h00
`define ADSR_MCYCLE_DIV 12
`define ADSR_CONV_MCYCLES 13
`define ADSR_DONE_LEAD 3
`endif

// file: adsr_pkg.sv
// types shared by the converter start/reference control
package adsr_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adsr_bus_req_type;

    typedef struct packed {
        logic [3:0] upper_step;
        logic [3:0] lower_step;
    } adsr_ref_type;

    typedef enum logic [1:0] {
        ADSR_IDLE,
        ADSR_PENDING,
        ADSR_CONVERT
    } adsr_state_type;
endpackage

// file: adsr_ctrl.sv
// converter start, mode and reference program control
//
// Contract
// - analog port pins always readable digitally
// - result register is eight bits wide
// - result holds until next completed conversion
// - software reads and writes the result
// - internal start: any reference write starts
// - single mode: one conversion per start
// - continuous internal: restart until mode cleared
// - external start: pin falling edge starts
// - external single: one per falling edge
// - external continuous: run while pin low
// - low nibble lower, high nibble upper
// - nibble selects one of sixteen steps
// - zero nibble selects external reference
// - result saturates outside internal references
// - reference write restarts a running conversion; here only under internal start
// - start pin sampled once per machine cycle
// - active flag read only, hardware cleared
// - result loads in last machine cycle
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "adsr_map.svh"

module adsr_ctrl #(
    parameter int MCYCLE_DIV = `ADSR_MCYCLE_DIV,
    parameter int CONV_MCYCLES = `ADSR_CONV_MCYCLES,
    parameter int DONE_LEAD = `ADSR_DONE_LEAD
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_ext_start_pin,
    input wire logic [7:0] i_analog_port_low,
    input wire logic [3:0] i_analog_port_high,
    output logic [7:0] o_analog_port_low,
    output logic [3:0] o_analog_port_high,
    input wire logic [7:0] i_core_code,
    input wire logic i_core_over,
    input wire logic i_core_under,
    output logic o_core_sample,
    output logic [3:0] o_internal_lower_reference,
    output logic [3:0] o_internal_upper_reference,
    output logic o_conversion_active_flag,
    output logic o_conversion_done_irq_flag
);
    localparam logic [4:0] LAST_MC = 5'(CONV_MCYCLES - 1);
    localparam logic [4:0] DONE_MC = 5'(CONV_MCYCLES - 1 - DONE_LEAD);
    localparam logic [3:0] DIV_LAST = 4'(MCYCLE_DIV - 1);

    adsr_pkg::adsr_bus_req_type req;
    adsr_pkg::adsr_ref_type ref_prog;
    adsr_pkg::adsr_state_type state_reg;
    logic [7:0] conversion_result_reg;
    logic [7:0] reference_program_reg;
    logic continuous_mode_select;
    logic external_start_select;
    logic [3:0] div_reg;
    logic mc_tick;
    logic [4:0] mc_count_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_sample_reg;
    logic pin_prev_reg;
    logic [7:0] port_low_meta_reg;
    logic [3:0] port_high_meta_reg;
    logic ref_wr;
    logic ext_fall;
    logic ext_low;
    logic last_mc;
    logic [7:0] code_sat;
    logic abort;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // bus request bundled for decode
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign ref_prog = reference_program_reg;
    assign ref_wr = req.wr && hit(req.addr, `ADSR_OFS_REFPROG);
    // only an internal-start write aborts; under external start it just stores nibbles
    assign abort = ref_wr && !external_start_select;
    assign last_mc = mc_tick && (mc_count_reg == LAST_MC);
    // edge seen between two machine-cycle samples
    assign ext_fall = pin_prev_reg && !pin_sample_reg;
    assign ext_low = !pin_sample_reg;
    // core flags saturate the code regardless of its raw bits
    assign code_sat = i_core_over ? 8'hFF : (i_core_under ? 8'h00 : i_core_code);

    // machine-cycle enable from the system clock
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            div_reg <= 4'h0;
        else if (div_reg == DIV_LAST)
            div_reg <= 4'h0;
        else
            div_reg <= div_reg + 4'h1;
    end
    assign mc_tick = (div_reg == DIV_LAST);

    // start pin: two-flop sync, then one sample per machine cycle
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            // idle high, so a pin held low at release is taken as a falling edge
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            pin_sample_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end
        else
        begin
            pin_meta_reg <= i_ext_start_pin;
            pin_sync_reg <= pin_meta_reg;
            if (mc_tick)
            begin
                pin_sample_reg <= pin_sync_reg;
                pin_prev_reg <= pin_sample_reg;
            end
        end
    end

    // digital view of analog pins, unaffected by converter activity
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            port_low_meta_reg <= 8'h00;
            port_high_meta_reg <= 4'h0;
            o_analog_port_low <= 8'h00;
            o_analog_port_high <= 4'h0;
        end
        else
        begin
            port_low_meta_reg <= i_analog_port_low;
            port_high_meta_reg <= i_analog_port_high;
            o_analog_port_low <= port_low_meta_reg;
            o_analog_port_high <= port_high_meta_reg;
        end
    end

    // mode select bits in the control register
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            continuous_mode_select <= 1'b0;
            external_start_select <= 1'b0;
        end
        else if (req.wr && hit(req.addr, `ADSR_OFS_CTRL))
        begin
            // the active bit of the write is dropped, hardware owns it
            continuous_mode_select <= req.wdata[`ADSR_CTRL_CONT_BIT];
            external_start_select <= req.wdata[`ADSR_CTRL_EXT_BIT];
        end
    end

    // reference program: any write stores nibbles
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            reference_program_reg <= `ADSR_REFPROG_RST;
        else if (ref_wr)
            reference_program_reg <= req.wdata;
    end

    // nibbles go to the resistor ladder; zero means the external rail
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_internal_lower_reference <= 4'h0;
            o_internal_upper_reference <= 4'h0;
        end
        else
        begin
            o_internal_lower_reference <= ref_prog.lower_step;
            o_internal_upper_reference <= ref_prog.upper_step;
        end
    end

    // conversion sequencer; a request waits for the next machine cycle
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_reg <= adsr_pkg::ADSR_IDLE;
            mc_count_reg <= 5'h00;
        end
        else if (abort)
        begin
            state_reg <= adsr_pkg::ADSR_PENDING;
            mc_count_reg <= 5'h00;
        end
        else
        begin
            unique case (state_reg)
                adsr_pkg::ADSR_IDLE:
                    // an edge that falls while busy is lost; single mode waits for a fresh one
                    if (mc_tick && external_start_select && ext_fall)
                    begin
                        state_reg <= adsr_pkg::ADSR_CONVERT;
                        mc_count_reg <= 5'h00;
                    end
                adsr_pkg::ADSR_PENDING:
                    // conversion begins on the next machine-cycle boundary
                    if (mc_tick)
                    begin
                        state_reg <= adsr_pkg::ADSR_CONVERT;
                        mc_count_reg <= 5'h00;
                    end
                adsr_pkg::ADSR_CONVERT:
                    if (last_mc)
                    begin
                        mc_count_reg <= 5'h00;
                        // restart decision taken at the final machine cycle
                        if (continuous_mode_select && !external_start_select)
                            state_reg <= adsr_pkg::ADSR_CONVERT;
                        else if (continuous_mode_select && external_start_select && ext_low)
                            state_reg <= adsr_pkg::ADSR_CONVERT;
                        else
                            state_reg <= adsr_pkg::ADSR_IDLE;
                    end
                    else if (mc_tick)
                        mc_count_reg <= mc_count_reg + 5'h01;
                // the unused fourth code falls back to idle
                default:
                    state_reg <= adsr_pkg::ADSR_IDLE;
            endcase
        end
    end

    // active flag drops early so polling software sees result on time
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_conversion_active_flag <= 1'b0;
        else
            o_conversion_active_flag <= (state_reg == adsr_pkg::ADSR_CONVERT)
                && (mc_count_reg < DONE_MC);
    end

    // done pulse ahead of the result, covering interrupt latency
    // an aborting write also cancels the pulse of the killed conversion
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_conversion_done_irq_flag <= 1'b0;
        else
            o_conversion_done_irq_flag <= (state_reg == adsr_pkg::ADSR_CONVERT) && mc_tick
                && (mc_count_reg == DONE_MC) && !abort;
    end

    // sample strobe to the analog core at each conversion start
    // the core tracks its inputs while this stands high and holds them once it drops
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_core_sample <= 1'b0;
        else
            o_core_sample <= (state_reg == adsr_pkg::ADSR_CONVERT) && (mc_count_reg == 5'h00);
    end

    // result: hardware load at last cycle wins over a software write
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            conversion_result_reg <= `ADSR_RESULT_RST;
        else if (state_reg == adsr_pkg::ADSR_CONVERT && last_mc && !abort)
            conversion_result_reg <= code_sat;
        else if (req.wr && hit(req.addr, `ADSR_OFS_RESULT))
            conversion_result_reg <= req.wdata;
        // otherwise held untouched
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_rdata <= 8'h00;
        else if (!req.rd)
            o_rdata <= 8'h00;
        else if (hit(req.addr, `ADSR_OFS_RESULT))
            o_rdata <= conversion_result_reg;
        else if (hit(req.addr, `ADSR_OFS_REFPROG))
            o_rdata <= reference_program_reg;
        else if (hit(req.addr, `ADSR_OFS_CTRL))
        begin
            // unused bits read zero beside the mode bits and the live active flag
            o_rdata <= 8'h00;
            o_rdata[`ADSR_CTRL_CONT_BIT] <= continuous_mode_select;
            o_rdata[`ADSR_CTRL_ACTIVE_BIT] <= o_conversion_active_flag;
            o_rdata[`ADSR_CTRL_EXT_BIT] <= external_start_select;
        end
        else
            o_rdata <= 8'h00;
    end
endmodule

// file: adsr_core_model.sv
// analog core stand-in that freezes level and range at sample time
`timescale 1ns/1ps
module adsr_core_model (
    input wire logic i_sys_clk,
    input wire logic i_sample,
    input wire logic [7:0] i_level,
    input wire logic [1:0] i_range,
    output logic [7:0] o_code,
    output logic o_over,
    output logic o_under
);
    // the array holds what it saw while sampling
    always_ff @(posedge i_sys_clk)
        if (i_sample)
        begin
            o_code <= i_level;
            o_over <= i_range[0];
            o_under <= i_range[1];
        end
endmodule

// file: adsr_ctrl_asserts.sv
// port checker for the converter start/reference control
`timescale 1ns/1ps
`include "adsr_map.svh"
module adsr_ctrl_chk #(
    parameter int MCYCLE_DIV = `ADSR_MCYCLE_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_ext_start_pin,
    input wire logic [7:0] i_analog_port_low,
    input wire logic [7:0] o_analog_port_low,
    input wire logic [3:0] i_analog_port_high,
    input wire logic [3:0] o_analog_port_high,
    input wire logic [3:0] o_internal_lower_reference,
    input wire logic [3:0] o_internal_upper_reference,
    input wire logic o_conversion_active_flag,
    input wire logic o_conversion_done_irq_flag
);
    localparam int ST = 3 * MCYCLE_DIV;
    localparam int RS = 6 * MCYCLE_DIV;
    logic [1:0] mode_reg;
    logic [1:0] up_reg;
    // mode bits mirrored from control writes: ext, cont
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
        if (i_sys_rst)
            mode_reg <= 2'h0;
        else if (i_wr && i_addr == `ADSR_OFS_CTRL)
            mode_reg <= {i_wdata[`ADSR_CTRL_EXT_BIT], i_wdata[`ADSR_CTRL_CONT_BIT]};
    // pin flops need two edges to refill after reset
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
        if (i_sys_rst)
            up_reg <= 2'h0;
        else if (up_reg != 2'h3)
            up_reg <= up_reg + 2'h1;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_ref_wr;
        i_wr && i_addr == `ADSR_OFS_REFPROG;
    endsequence
    sequence s_pin_low;
        $fell(i_ext_start_pin) && !o_conversion_active_flag ##1 !i_ext_start_pin [*5];
    endsequence
    a_port_view: assert property (up_reg == 2'h3 |-> o_analog_port_low == $past(i_analog_port_low, 2))
        else $error("port view wrong");
    a_port_high: assert property (up_reg == 2'h3 |-> o_analog_port_high == $past(i_analog_port_high, 2))
        else $error("high port view wrong");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside slot");
    a_ref_nibble: assert property (s_ref_wr |=> ##1
        {o_internal_upper_reference, o_internal_lower_reference} == $past(i_wdata, 2))
        else $error("reference nibbles wrong");
    a_int_start: assert property (s_ref_wr ##0 !mode_reg[1] |-> ##[1:ST] o_conversion_active_flag)
        else $error("write did not start");
    a_ext_start: assert property (s_pin_low ##0 mode_reg[1] |-> ##[0:ST] o_conversion_active_flag)
        else $error("pin edge did not start");
    a_single_stop: assert property (o_conversion_done_irq_flag && mode_reg == 2'h0 |=> !o_conversion_active_flag [*8])
        else $error("single mode restarted");
    a_cont_restart: assert property (o_conversion_done_irq_flag && mode_reg == 2'h1 |-> ##[1:RS] o_conversion_active_flag)
        else $error("continuous did not restart");
    a_done_gap: assert property (o_conversion_done_irq_flag |=> !o_conversion_done_irq_flag [*8])
        else $error("done pulse too close");
    a_busy_before_done: assert property (o_conversion_done_irq_flag |-> !o_conversion_active_flag)
        else $error("active flag still set at done");
endmodule
bind adsr_ctrl adsr_ctrl_chk #(.MCYCLE_DIV(MCYCLE_DIV)) u_chk (.i_sys_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_ext_start_pin, .i_analog_port_low, .o_analog_port_low, .i_analog_port_high,
    .o_analog_port_high, .o_internal_lower_reference,
    .o_internal_upper_reference, .o_conversion_active_flag, .o_conversion_done_irq_flag);

// file: testbench.sv
// self-checking bench for the converter start/reference control
`timescale 1ns/1ps
`include "adsr_map.svh"
module testbench;
    logic clk, rst, wr, rd, rd_d, pin, smp, ovr, und, act, done;
    logic [7:0] addr, wdata, rdata, level, code, v;
    logic [1:0] range;
    logic [31:0] lfsr;
    logic [7:0] exp_q[$];
    int n_mismatch, samples_checked, n_done, base, cyc;
    adsr_ctrl #(.MCYCLE_DIV(2)) DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_ext_start_pin(pin), .i_analog_port_low(lfsr[7:0]),
        .i_analog_port_high(lfsr[11:8]), .o_analog_port_low(), .o_analog_port_high(), .i_core_code(code),
        .i_core_over(ovr), .i_core_under(und), .o_core_sample(smp), .o_internal_lower_reference(),
        .o_internal_upper_reference(), .o_conversion_active_flag(act), .o_conversion_done_irq_flag(done));
    adsr_core_model u_core (.i_sys_clk(clk), .i_sample(smp), .i_level(level), .i_range(range), .o_code(code),
        .o_over(ovr), .o_under(und));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // idle edge so a following call never re-drives the strobe in one step
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // idle edge so a following call never re-drives the strobe in one step
        @(posedge clk);
    endtask
    // legal nibbles: lower under 8, upper four to seven steps higher
    task automatic start(input logic [1:0] rg, input logic [7:0] lv);
        level <= lv;
        range <= rg;
        wr_reg(`ADSR_OFS_REFPROG, {{1'b0, lfsr[2:0]} + 4'h4 + {2'h0, lfsr[4:3]}, 1'b0, lfsr[2:0]});
    endtask
    task automatic wait_done();
        while (done !== 1'b1)
            @(posedge clk);
        repeat (12) @(posedge clk);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // random pins, done counting, read monitor and hang guard
    always @(posedge clk)
    begin
        lfsr <= lfsr_next(lfsr);
        rd_d <= rd;
        n_done += (done === 1'b1);
        cyc++;
        if (rd_d === 1'b1)
            check(rdata, exp_q.pop_front());
        if (cyc == 8000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        {rst, wr, rd, pin, addr, wdata, level, range} = {1'b1, 3'h1, 26'h0};
        lfsr = 32'h00011758;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`ADSR_OFS_RESULT, `ADSR_RESULT_RST);
        rd_reg(`ADSR_OFS_REFPROG, `ADSR_REFPROG_RST);
        rd_reg(8'hD7, 8'h00);
        v = lfsr[15:8];
        wr_reg(`ADSR_OFS_RESULT, v);
        rd_reg(`ADSR_OFS_RESULT, v);
        wr_reg(`ADSR_OFS_CTRL, 8'h10);
        rd_reg(`ADSR_OFS_CTRL, 8'h00);
        $display("registers done");
        for (int i = 0; i < 3; i++)
        begin
            v = lfsr[15:8];
            start(i[1:0], v);
            wait_done();
            rd_reg(`ADSR_OFS_RESULT, (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : v);
            repeat (20) @(posedge clk);
            rd_reg(`ADSR_OFS_RESULT, (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : v);
        end
        $display("single and saturation done");
        base = n_done;
        start(2'h0, 8'h3C);
        repeat (10) @(posedge clk);
        start(2'h0, 8'hC3);
        wait_done();
        repeat (30) @(posedge clk);
        check(8'(n_done - base), 8'h01);
        rd_reg(`ADSR_OFS_RESULT, 8'hC3);
        $display("restart done");
        wr_reg(`ADSR_OFS_CTRL, 8'h08);
        base = n_done;
        start(2'h0, lfsr[15:8]);
        repeat (100) @(posedge clk);
        check(8'(n_done - base >= 3), 8'h01);
        while (act !== 1'b1)
            @(posedge clk);
        wr_reg(`ADSR_OFS_CTRL, 8'h00);
        base = n_done;
        repeat (100) @(posedge clk);
        check(8'(n_done - base), 8'h01);
        $display("continuous done");
        wr_reg(`ADSR_OFS_CTRL, 8'h20);
        base = n_done;
        start(2'h0, lfsr[15:8]);
        repeat (60) @(posedge clk);
        check(8'(n_done - base), 8'h00);
        pin <= 1'b0;
        repeat (10) @(posedge clk);
        pin <= 1'b1;
        repeat (80) @(posedge clk);
        check(8'(n_done - base), 8'h01);
        wr_reg(`ADSR_OFS_CTRL, 8'h28);
        base = n_done;
        pin <= 1'b0;
        repeat (80) @(posedge clk);
        check(8'(n_done - base >= 2), 8'h01);
        pin <= 1'b1;
        base = n_done;
        repeat (60) @(posedge clk);
        check(8'(n_done - base < 2), 8'h01);
        base = n_done;
        repeat (60) @(posedge clk);
        check(8'(n_done - base), 8'h00);
        $display("external done");
        stop_test();
    end
endmodule
